// >>> rtl/sar_adc_ctrl.sv
// Converter control, resolution select and result registers
`timescale 1ns/10ps
module sar_adc_ctrl
	import sar_adc_pkg::*;
#(
	parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [19:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Analog front end
	input  wire logic [9:0]  analog_code,
	output logic      [3:0]  channel_sel,
	output logic             sample_hold,
	output logic             cmp_power,
	// Status
	output logic             conv_busy,
	output logic             conv_done
);

	// Settle counter is eight bits wide and must end above zero
	if (SETTLE_COUNT < 1 || SETTLE_COUNT > 255) begin : g_bad_settle
		$error("SETTLE_COUNT out of range");
	end

	// Register state
	logic [1:0]  clk_sel;
	logic        sample_short;
	logic        cmp_en;
	logic        run;
	logic        res_8bit;
	logic [15:0] result_word;

	// Conversion state
	conv_state_t state;
	logic [4:0]  phase_cnt;
	logic [9:0]  sar;
	logic [9:0]  held_code;
	logic [9:0]  code_meta;
	logic [9:0]  code_sync;

	// Settling and warnings
	logic [7:0]  settle_cnt;
	logic        settled;
	logic        unsettled_result;
	logic        source_conflict;

	// Decoded strobes and timing values
	logic        wr_mode;
	logic        wr_res;
	logic        wr_chan;
	logic        conv_end;
	logic        start;
	logic        abort;
	logic [4:0]  sample_clks;
	logic [4:0]  total_clks;
	logic [4:0]  conv_clks;
	logic [4:0]  trials;
	logic [3:0]  trial_bit;
	logic [9:0]  trial_val;
	logic [1:0]  op_state;
	logic [15:0] next_rdata;

	conv_clk_if clk_link ();

	conv_clk_div u_div (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_port (clk_link.div)
	);

	assign clk_link.enable  = state != ST_IDLE && state != ST_FINISH;
	assign clk_link.clk_sel = clk_sel;

	// Write decode; result addresses have no write path
	assign wr_mode = reg_wr && reg_addr == MODE_ADDR;
	assign wr_res  = reg_wr && reg_addr == RESOLUTION_ADDR;
	assign wr_chan = reg_wr && reg_addr == CHANNEL_ADDR;

	// Analog code synchroniser
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			code_meta <= 10'h000;
			code_sync <= 10'h000;
		end else begin
			code_meta <= analog_code;
			code_sync <= code_meta;
		end
	end

	// Clock select, sampling time, comparator enable
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			clk_sel      <= CLK_SEL_RESET;
			sample_short <= 1'b0;
			cmp_en       <= 1'b0;
		end else if (wr_mode) begin
			clk_sel      <= {reg_wdata[CLK_HI_BIT], reg_wdata[CLK_LO_BIT]};
			sample_short <= reg_wdata[SAMPLE_BIT];
			cmp_en       <= reg_wdata[CMP_EN_BIT];
		end
	end

	// Run bit: set only with comparator already on, cleared at end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run <= 1'b0;
		end else if (wr_mode) begin
			run <= reg_wdata[RUN_BIT] && cmp_en
				&& reg_wdata[CMP_EN_BIT];
		end else if (conv_end) begin
			run <= 1'b0;
		end
	end

	// Resolution register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			res_8bit <= RES_RESET[RES_SEL_BIT];
		end else if (wr_res) begin
			res_8bit <= reg_wdata[RES_SEL_BIT];
		end
	end

	// Channel select register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			channel_sel <= CHANNEL_RESET;
		end else if (wr_chan) begin
			channel_sel <= reg_wdata[3:0];
		end
	end

	// Comparator settling time after enable
	always_ff @(posedge core_clk) begin
		if (!rst_n || !cmp_en) begin
			settle_cnt <= 8'h00;
		end else if (!settled) begin
			settle_cnt <= settle_cnt + 8'h01;
		end
	end

	assign settled = settle_cnt == 8'(SETTLE_COUNT);

	// Conversion timing per resolution and sampling time
	always_comb begin
		sample_clks = sample_short ? SAMPLE_SHORT : SAMPLE_LONG;
		if (res_8bit) begin
			total_clks = sample_short ? TOTAL_8_SHORT : TOTAL_8_LONG;
			trials     = TRIALS_8;
		end else begin
			total_clks = sample_short ? TOTAL_10_SHORT : TOTAL_10_LONG;
			trials     = TRIALS_10;
		end
		conv_clks = total_clks - sample_clks;
	end

	assign start    = state == ST_IDLE && run;
	assign abort    = !run && (state == ST_SAMPLE || state == ST_CONVERT);
	assign conv_end = state == ST_FINISH;

	// Successive approximation trial
	assign trial_bit = 4'h9 - phase_cnt[3:0];
	assign trial_val = sar | (10'h001 << trial_bit);

	// Conversion sequence
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			phase_cnt <= 5'h00;
			sar       <= 10'h000;
			held_code <= 10'h000;
		end else if (abort) begin
			state     <= ST_IDLE;
			phase_cnt <= 5'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					phase_cnt <= 5'h00;
					if (start) begin
						state <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					if (clk_link.tick) begin
						if (phase_cnt == sample_clks - 5'h01) begin
							held_code <= code_sync;
							sar       <= 10'h000;
							phase_cnt <= 5'h00;
							state     <= ST_CONVERT;
						end else begin
							phase_cnt <= phase_cnt + 5'h01;
						end
					end
				end
				ST_CONVERT: begin
					if (clk_link.tick) begin
						// 8-bit mode stops before the two lowest bits
						if (phase_cnt < trials) begin
							sar[trial_bit] <= trial_val <= held_code;
						end
						if (phase_cnt == conv_clks - 5'h01) begin
							state <= ST_FINISH;
						end
						phase_cnt <= phase_cnt + 5'h01;
					end
				end
				ST_FINISH: begin
					state     <= ST_IDLE;
					phase_cnt <= 5'h00;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Result word, ten bits aligned to bit 15
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			result_word <= RESULT_RESET;
		end else if (conv_end) begin
			result_word <= {sar, {RESULT_ZEROS{1'b0}}};
		end
	end

	// Result of a start before comparator settled
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			unsettled_result <= 1'b0;
		end else if (start) begin
			unsettled_result <= !settled;
		end
	end

	// Short sampling with an internal source selected
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			source_conflict <= 1'b0;
		end else begin
			source_conflict <= sample_short && channel_sel >= CH_TOUCH
				&& channel_sel <= CH_VREF;
		end
	end

	// Operating state from run and comparator enable
	always_comb begin
		if (run) begin
			op_state = OP_CONVERTING;
		end else if (cmp_en) begin
			op_state = OP_STANDBY;
		end else begin
			op_state = OP_STOPPED;
		end
	end

	// Read multiplexer
	always_comb begin
		next_rdata = 16'h0000;
		case (reg_addr)
			RESULT_WORD_ADDR: begin
				next_rdata = result_word;
			end
			RESULT_HIGH_ADDR: begin
				next_rdata = {8'h00, result_word[15:8]};
			end
			RESOLUTION_ADDR: begin
				next_rdata = {15'h0000, res_8bit};
			end
			MODE_ADDR: begin
				next_rdata = {8'h00, run, 2'h0, clk_sel[1], clk_sel[0],
					1'b0, sample_short, cmp_en};
			end
			CHANNEL_ADDR: begin
				next_rdata = {12'h000, channel_sel};
			end
			STATUS_ADDR: begin
				next_rdata = {10'h000, op_state, source_conflict,
					unsettled_result, settled, conv_busy};
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// Read data stands only in the cycle after each cycle with reg_rd high, zero otherwise
	always_ff @(posedge core_clk) begin
		if (!rst_n || !reg_rd) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// Registered status outputs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			conv_busy   <= 1'b0;
			conv_done   <= 1'b0;
			sample_hold <= 1'b0;
			cmp_power   <= 1'b0;
		end else begin
			conv_busy   <= state != ST_IDLE;
			conv_done   <= conv_end;
			sample_hold <= state == ST_SAMPLE;
			cmp_power   <= cmp_en;
		end
	end

endmodule

// >>> rtl/sar_adc_pkg.sv
// Shared constants and types of the converter control block
package sar_adc_pkg;

	// Register addresses
	localparam logic [19:0] RESOLUTION_ADDR  = 20'hF0010;
	localparam logic [19:0] RESULT_WORD_ADDR = 20'hFFF1E;
	localparam logic [19:0] RESULT_HIGH_ADDR = 20'hFFF1F;
	localparam logic [19:0] MODE_ADDR        = 20'hFFF30;
	localparam logic [19:0] CHANNEL_ADDR     = 20'hFFF31;
	localparam logic [19:0] STATUS_ADDR      = 20'hFFF32;

	// Mode and resolution register field positions, result zero padding
	localparam int RUN_BIT      = 7;
	localparam int CLK_HI_BIT   = 4;
	localparam int CLK_LO_BIT   = 3;
	localparam int SAMPLE_BIT   = 1;
	localparam int CMP_EN_BIT   = 0;
	localparam int RES_SEL_BIT  = 0;
	localparam int RESULT_ZEROS = 6;

	// Reset values
	localparam logic [1:0]  CLK_SEL_RESET = 2'h0;
	localparam logic [7:0]  RES_RESET     = 8'h00;
	localparam logic [3:0]  CHANNEL_RESET = 4'h0;
	localparam logic [15:0] RESULT_RESET  = 16'h0000;

	// Conversion clock counts per conversion
	localparam logic [4:0] SAMPLE_LONG    = 5'h09;
	localparam logic [4:0] SAMPLE_SHORT   = 5'h03;
	localparam logic [4:0] TOTAL_8_LONG   = 5'h15;
	localparam logic [4:0] TOTAL_8_SHORT  = 5'h0F;
	localparam logic [4:0] TOTAL_10_LONG  = 5'h17;
	localparam logic [4:0] TOTAL_10_SHORT = 5'h11;
	localparam logic [4:0] TRIALS_8       = 5'h08;
	localparam logic [4:0] TRIALS_10      = 5'h0A;

	// Comparator settling time
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int SETTLE_TIME_PS = 100000;
	localparam int SETTLE_CYCLES  =
		(SETTLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Internal sources that need long sampling
	localparam logic [3:0] CH_TOUCH = 4'hB;
	localparam logic [3:0] CH_VREF  = 4'hD;

	// Operating state codes in the status register
	localparam logic [1:0] OP_STOPPED    = 2'h0;
	localparam logic [1:0] OP_STANDBY    = 2'h1;
	localparam logic [1:0] OP_CONVERTING = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT,
		ST_FINISH
	} conv_state_t;

endpackage

// >>> rtl/conv_clk_if.sv
// Conversion clock request and tick between control and divider
`timescale 1ns/10ps
interface conv_clk_if;
	logic       enable;
	logic [1:0] clk_sel;
	logic       tick;

	modport ctrl (output enable, output clk_sel, input tick);
	modport div  (input enable, input clk_sel, output tick);
endinterface

// >>> rtl/conv_clk_div.sv
// Conversion clock enable divider
`timescale 1ns/10ps
module conv_clk_div
	import sar_adc_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Control side
	conv_clk_if.div   clk_port
);

	logic [2:0] count;
	logic [2:0] limit;

	// Divide by 8, 4, 2, 1 for select 00, 01, 10, 11
	assign limit = 3'(4'h8 >> clk_port.clk_sel) - 3'h1;

	always_ff @(posedge core_clk) begin
		if (!rst_n || !clk_port.enable || count == limit) begin
			count <= 3'h0;
		end else begin
			count <= count + 3'h1;
		end
	end

	assign clk_port.tick = clk_port.enable && count == limit;

endmodule

// >>> bench/sar_adc_ctrl_sva.sv
// Port assertions of the converter control block
`timescale 1ns/10ps
module sar_adc_ctrl_sva
	import sar_adc_pkg::*;
#(
	parameter int SETTLE_COUNT = 2
) (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Register port
	input wire logic [19:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Status
	input wire logic        cmp_power,
	input wire logic        conv_busy,
	input wire logic        conv_done
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic       res8;
	logic       last8;
	logic       prev_busy;
	logic [9:0] busy_len;

	// Resolution written by software
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			res8 <= 1'b0;
		else if (reg_wr && reg_addr == RESOLUTION_ADDR)
			res8 <= reg_wdata[0];
	end

	// Resolution of the last finished conversion
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			last8 <= 1'b0;
		else if (conv_done)
			last8 <= res8;
	end

	// Length of the latest busy stretch
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prev_busy <= 1'b0;
			busy_len  <= 10'h000;
		end else begin
			prev_busy <= conv_busy;
			if (conv_busy && !prev_busy)
				busy_len <= 10'h001;
			else if (conv_busy)
				busy_len <= busy_len + 10'h001;
		end
	end

	sequence word_rd;
		reg_rd && reg_addr == RESULT_WORD_ADDR && !conv_done;
	endsequence
	sequence high_rd;
		reg_rd && reg_addr == RESULT_HIGH_ADDR && !conv_done;
	endsequence

	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside read");
	AST_RES_UPPER: assert property (
		reg_rd && reg_addr == RESOLUTION_ADDR |=> reg_rdata[15:1] == 15'h0000)
		else $error("resolution upper bits not zero");
	AST_WORD_LOW: assert property (word_rd |=> reg_rdata[5:0] == 6'h00)
		else $error("result word low bits not zero");
	AST_HIGH_MATCH: assert property (word_rd ##1 high_rd |=>
		reg_rdata == {8'h00, $past(reg_rdata[15:8])})
		else $error("high byte differs from result word");
	AST_8BIT_LOW: assert property (word_rd ##0 last8 |=>
		reg_rdata[7:6] == 2'h0)
		else $error("8-bit result has low bits set");
	AST_DONE_PULSE: assert property (conv_done |=> !conv_done)
		else $error("done longer than one cycle");
	AST_MIN_LENGTH: assert property (conv_done |-> busy_len >= 10'd14)
		else $error("conversion finished too soon");
	AST_CMP_FOLLOW: assert property (
		reg_wr && reg_addr == MODE_ADDR |-> ##2 cmp_power == $past(reg_wdata[0], 2))
		else $error("comparator enable not following mode write");
	AST_RUN_REFUSED: assert property (
		reg_wr && reg_addr == MODE_ADDR && reg_wdata[7] && !reg_wdata[0]
		|-> ##3 !conv_busy [*4])
		else $error("run without comparator started a conversion");
endmodule

bind sar_adc_ctrl sar_adc_ctrl_sva #(.SETTLE_COUNT(SETTLE_COUNT)) u_sva (
	.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.cmp_power, .conv_busy, .conv_done);

// >>> bench/sar_adc_resolution_result_tb_top.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sar_adc_resolution_result_tb_top
	import sar_adc_pkg::*;
;
	logic        core_clk;
	logic        rst_n;
	logic [19:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [9:0]  analog_code;
	logic [3:0]  channel_sel;
	logic        sample_hold;
	logic        cmp_power;
	logic        conv_busy;
	logic        conv_done;
	int          fails;
	int          num_checks;
	int          cycles;
	logic [15:0] d;
	logic [15:0] h;

	sar_adc_ctrl #(.SETTLE_COUNT(2)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .analog_code(analog_code),
		.channel_sel(channel_sel), .sample_hold(sample_hold),
		.cmp_power(cmp_power), .conv_busy(conv_busy),
		.conv_done(conv_done));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task results;
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			results();
		end
	end

	task wr(input logic [19:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [19:0] a, output logic [15:0] v);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Word then high byte, back to back
	task rd2(output logic [15:0] w, output logic [15:0] hb);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= RESULT_WORD_ADDR;
		@(posedge core_clk);
		reg_addr <= RESULT_HIGH_ADDR;
		#1 w = reg_rdata;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 hb = reg_rdata;
	endtask

	task t_reset;
		rd(RESOLUTION_ADDR, d);
		`CHK(d, 16'h0000)
		rd2(d, h);
		`CHK(d, 16'h0000)
		`CHK(h, 16'h0000)
	endtask

	task t_regs;
		wr(RESOLUTION_ADDR, 8'hFF);
		rd(RESOLUTION_ADDR, d);
		`CHK(d, 16'h0001)
		wr(RESOLUTION_ADDR, 8'h00);
		rd(RESOLUTION_ADDR, d);
		`CHK(d, 16'h0000)
		rd(20'hF0011, d);
		`CHK(d, 16'h0000)
		wr(CHANNEL_ADDR, 8'hF5);
		rd(CHANNEL_ADDR, d);
		`CHK(d, 16'h0005)
		`CHK(channel_sel, 4'h5)
	endtask

	task t_conv(input logic r8, input logic [1:0] sel, input logic sh,
			input logic [9:0] code);
		int          n;
		int          tot;
		int          cyc;
		int          hold;
		logic [15:0] e;
		n   = 8 >> sel;
		tot = r8 ? (sh ? 15 : 21) : (sh ? 17 : 23);
		e   = r8 ? {code[9:2], 8'h00} : {code, 6'h00};
		analog_code <= code;
		wr(RESOLUTION_ADDR, {7'h00, r8});
		wr(MODE_ADDR, {3'h0, sel, 1'b0, sh, 1'b1});
		repeat (4) @(posedge core_clk);
		`CHK(cmp_power, 1'b1)
		rd(STATUS_ADDR, d);
		`CHK(d[5:4], OP_STANDBY)
		wr(MODE_ADDR, {3'h4, sel, 1'b0, sh, 1'b1});
		cyc  = 0;
		hold = 0;
		while (conv_done !== 1'b1 && cyc < 400) begin
			@(posedge core_clk);
			#1 cyc++;
			if (sample_hold === 1'b1)
				hold++;
		end
		`CHK(cyc, tot * n + 2)
		`CHK(hold, (sh ? 3 : 9) * n)
		wr(RESULT_WORD_ADDR, 8'h3C);
		wr(RESULT_HIGH_ADDR, 8'h3C);
		rd2(d, h);
		`CHK(d, e)
		`CHK(h, {8'h00, e[15:8]})
		wr(MODE_ADDR, 8'h00);
		wr(MODE_ADDR, 8'h80);
		repeat (4) @(posedge core_clk);
		`CHK(conv_busy, 1'b0)
		`CHK(cmp_power, 1'b0)
	endtask

	initial begin
		rst_n       = 1'b0;
		reg_addr    = 20'h00000;
		reg_wdata   = 8'h00;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		analog_code = 10'h000;
		fails       = 0;
		num_checks  = 0;
		cycles      = 0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_conv(1'b1, 2'h3, 1'b0, 10'h2D5);
		t_conv(1'b1, 2'h0, 1'b1, 10'h0FF);
		t_conv(1'b1, 2'h2, 1'b0, 10'h3FF);
		t_conv(1'b1, 2'h1, 1'b1, 10'h001);
		wr(RESOLUTION_ADDR, 8'h00);
		t_conv(1'b0, 2'h3, 1'b0, 10'h2D7);
		t_conv(1'b0, 2'h1, 1'b1, 10'h203);
		results();
	end
endmodule
